// ==== akp_pkg.sv ====
// register map, field layout, reset values and state codes of the
// parallel-port command sequencer.
// assumes a 32-bit Avalon-MM slave with byte addresses.
package akp_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam int unsigned AW             = 5;
  localparam logic [4:0]  REG_COMMAND    = 5'h00;
  localparam logic [4:0]  REG_STATUS     = 5'h04;
  localparam logic [4:0]  REG_ALT_STATUS = 5'h08;
  localparam logic [4:0]  REG_DATA       = 5'h0c;
  localparam logic [4:0]  REG_CONTROL    = 5'h10;
  localparam logic [4:0]  REG_CONFIG     = 5'h14;
  localparam logic [4:0]  REG_ERROR      = 5'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CMD_PIO_IN_BIT  = 0;
  localparam int unsigned CMD_IDENT_BIT   = 1;
  localparam int unsigned CMD_OPC_LSB     = 8;
  localparam int unsigned OPC_W           = 8;
  localparam int unsigned CTRL_IDIS_BIT   = 1;
  localparam int unsigned STS_ERR_BIT     = 0;
  localparam int unsigned STS_DRQ_BIT     = 3;
  localparam int unsigned STS_PEND_BIT    = 4;
  localparam int unsigned STS_BUSY_BIT    = 7;
  localparam int unsigned CFG_BLK_LSB     = 16;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned ERR_W           = 8;
  localparam int unsigned IDENT_CBL_BIT   = 13;
  localparam logic [15:0] IDENT_CBL_WORD  = 16'h005d;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_WORDS  = 16'h0100;
  localparam logic [15:0] RST_BLOCKS = 16'h0001;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_ND_EXEC = 3'b001,
    S_PI_PREP = 3'b010,
    S_PI_RDY  = 3'b011,
    S_PI_XFER = 3'b100
  } akp_state_t;

endpackage : akp_pkg

// ==== akp_xfer_count.sv ====
// word-in-block and block-in-command counter for data-in transfers.
// assumes load and word_taken are single-cycle pulses, never together.
`timescale 1ns/1ns
module akp_xfer_count #(
  parameter int unsigned CW = 16
) (
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  input  wire logic          load_i,
  input  wire logic [CW-1:0] words_i,
  input  wire logic [CW-1:0] blocks_i,
  input  wire logic          word_taken_i,
  output logic      [CW-1:0] word_idx_o,
  output logic               last_word_o,
  output logic               last_block_o
);

  logic [CW-1:0] word_q;
  logic [CW-1:0] word_d;
  logic [CW-1:0] blk_q;
  logic [CW-1:0] blk_d;
  wire  [CW-1:0] words_m1;
  wire  [CW-1:0] blocks_m1;
  wire  [CW-1:0] one;

  assign one       = CW'(1);
  // a length of zero is taken as one
  assign words_m1  = (words_i == '0) ? '0 : words_i - one;
  assign blocks_m1 = (blocks_i == '0) ? '0 : blocks_i - one;

  assign word_idx_o   = word_q;
  assign last_word_o  = (word_q == words_m1);
  assign last_block_o = (blk_q == '0);

  always_comb begin
    word_d = word_q;
    blk_d  = blk_q;
    if (load_i) begin
      word_d = '0;
      blk_d  = blocks_m1;
    end else if (word_taken_i) begin
      if (last_word_o) begin
        word_d = '0;
        if (!last_block_o) begin
          blk_d = blk_q - one;
        end
      end else begin
        word_d = word_q + one;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_q <= '0;
      blk_q  <= '0;
    end else begin
      word_q <= word_d;
      blk_q  <= blk_d;
    end
  end

endmodule : akp_xfer_count

// ==== akp_device.sv ====
// device-side command sequencer: non-data and PIO data-in protocols,
// with task-file registers on an Avalon-MM slave.
// assumes a back end that executes commands and supplies data words.
//
// How it works
// - non-data command write raises busy next cycle, executes, sets pending
// - non-data done, interrupts enabled: errors, busy off, line asserted
// - non-data done, interrupts disabled: errors, busy off, line stays low
// - data-in command write raises busy next cycle and starts preparing
// - identify commands patch cable level into bit 13 of word 93
// - abort during preparation: errors, busy off, line only if enabled
// - block ready: drq with line if enabled, else straight to transfer
// - status read while block waits clears pending, line, enters transfer
// - transfer shows drq, no busy, no line, one word ready per read
// - last word of non-final block returns to preparation
// - last word of final block goes idle without pending
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module akp_device #(
  parameter int unsigned DW = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  // avalon-mm slave
  input  wire logic [4:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // host side line
  output logic                  host_interrupt_line_o,
  input  wire logic             cable_detect_input_i,
  // back end
  output logic                  cmd_start_o,
  output logic      [7:0]       cmd_opcode_o,
  output logic                  cmd_pio_in_o,
  input  wire logic             nd_done_i,
  input  wire logic             prep_abort_i,
  input  wire logic [7:0]       error_i,
  input  wire logic             block_ready_i,
  output logic                  word_req_o,
  input  wire logic             word_valid_i,
  input  wire logic [DW-1:0]    word_data_i
);

  // ****************************************************************
  // state
  // ****************************************************************
  akp_pkg::akp_state_t state_q;
  akp_pkg::akp_state_t state_d;
  logic                pend_q;
  logic                pend_d;
  logic                line_q;
  logic                idis_q;
  logic                idis_d;
  logic [15:0]         words_q;
  logic [15:0]         words_d;
  logic [15:0]         blocks_q;
  logic [15:0]         blocks_d;
  logic [7:0]          err_q;
  logic [7:0]          err_d;
  logic                ident_q;
  logic                ident_d;
  logic                cable_q;
  logic                cable_d;
  logic                first_q;
  logic                first_d;
  logic [DW-1:0]       data_q;
  logic [DW-1:0]       data_d;
  logic                full_q;
  logic                full_d;
  logic                wreq_q;
  logic                wreq_d;
  logic                start_q;
  logic                start_d;
  logic [7:0]          opc_q;
  logic [7:0]          opc_d;
  logic                pio_q;
  logic                pio_d;
  logic                wait_q;
  logic [31:0]         rdata_q;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire        hit_cmd, hit_sts, hit_alt, hit_data, hit_ctrl, hit_cfg, hit_err;
  wire        stall, acc, acc_rd, acc_wr;
  wire        cmd_wr, sts_rd, data_rd, ctrl_wr, cfg_wr;
  wire        busy, data_request_bit;
  wire [31:0] status_word;
  wire [31:0] wmask;
  wire [31:0] cfg_word;
  wire [31:0] cfg_new;
  wire [31:0] rdata_d;
  wire [15:0] word_idx;
  wire        last_word;
  wire        last_block;
  wire        patch;
  wire [DW-1:0] word_in;

  assign hit_cmd  = (avs_address_i == akp_pkg::REG_COMMAND);
  assign hit_sts  = (avs_address_i == akp_pkg::REG_STATUS);
  assign hit_alt  = (avs_address_i == akp_pkg::REG_ALT_STATUS);
  assign hit_data = (avs_address_i == akp_pkg::REG_DATA);
  assign hit_ctrl = (avs_address_i == akp_pkg::REG_CONTROL);
  assign hit_cfg  = (avs_address_i == akp_pkg::REG_CONFIG);
  assign hit_err  = (avs_address_i == akp_pkg::REG_ERROR);

  // a data read in transfer holds off until the word is present
  assign stall   = avs_read_i & hit_data & (state_q == akp_pkg::S_PI_XFER)
                   & ~full_q;
  assign acc     = (avs_read_i | avs_write_i) & wait_q & ~stall;
  assign acc_rd  = acc & avs_read_i;
  assign acc_wr  = acc & avs_write_i;
  // commands are refused unless the sequencer is idle
  assign cmd_wr  = acc_wr & hit_cmd & (state_q == akp_pkg::S_IDLE);
  assign sts_rd  = acc_rd & hit_sts;
  assign data_rd = acc_rd & hit_data & (state_q == akp_pkg::S_PI_XFER);
  assign ctrl_wr = acc_wr & hit_ctrl;
  assign cfg_wr  = acc_wr & hit_cfg;

  assign busy = (state_q == akp_pkg::S_ND_EXEC)
              | (state_q == akp_pkg::S_PI_PREP);
  assign data_request_bit  = (state_q == akp_pkg::S_PI_RDY)
              | (state_q == akp_pkg::S_PI_XFER);

  assign status_word = (32'(busy) << akp_pkg::STS_BUSY_BIT)
                     | (32'(data_request_bit) << akp_pkg::STS_DRQ_BIT)
                     | (32'(pend_q) << akp_pkg::STS_PEND_BIT)
                     | (32'(err_q != '0) << akp_pkg::STS_ERR_BIT);

  // byte enables mask config writes lane by lane
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{avs_byteenable_i[b]}};
    end
  endgenerate

  assign cfg_word = {blocks_q, words_q};
  assign cfg_new  = (cfg_word & ~wmask) | (avs_writedata_i & wmask);

  assign rdata_d = (hit_sts | hit_alt) ? status_word
                 : hit_data            ? 32'(data_q)
                 : hit_ctrl            ? 32'(idis_q)
                                         << akp_pkg::CTRL_IDIS_BIT
                 : hit_cfg             ? cfg_word
                 : hit_err             ? 32'(err_q)
                 : akp_pkg::RST_ZERO;

  // ****************************************************************
  // counters and identify patch
  // ****************************************************************
  akp_xfer_count #(
    .CW           (akp_pkg::CNT_W)
  ) u_count (
    .mclk_i       (mclk_i),
    .nrst_i       (nrst_i),
    .load_i       (cmd_wr & pio_d),
    .words_i      (words_q),
    .blocks_i     (blocks_q),
    .word_taken_i (data_rd),
    .word_idx_o   (word_idx),
    .last_word_o  (last_word),
    .last_block_o (last_block)
  );

  assign patch = ident_q & first_q
               & (word_idx == akp_pkg::IDENT_CBL_WORD);
  assign word_in = patch
                 ? ((word_data_i & ~(DW'(1) << akp_pkg::IDENT_CBL_BIT))
                    | (DW'(cable_q) << akp_pkg::IDENT_CBL_BIT))
                 : word_data_i;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d  = state_q;
    pend_d   = pend_q;
    err_d    = err_q;
    ident_d  = ident_q;
    cable_d  = cable_q;
    first_d  = first_q;
    wreq_d   = 1'b0;
    start_d  = 1'b0;
    opc_d    = opc_q;
    pio_d    = avs_writedata_i[akp_pkg::CMD_PIO_IN_BIT];
    idis_d   = ctrl_wr ? avs_writedata_i[akp_pkg::CTRL_IDIS_BIT] : idis_q;
    words_d  = cfg_wr ? cfg_new[15:0] : words_q;
    blocks_d = cfg_wr ? cfg_new[31:akp_pkg::CFG_BLK_LSB] : blocks_q;
    full_d   = full_q;
    data_d   = data_q;
    if (word_valid_i && !full_q) begin
      full_d = 1'b1;
      data_d = word_in;
    end
    case (state_q)
      akp_pkg::S_IDLE: begin
        if (sts_rd) begin
          pend_d = 1'b0;
        end
        if (cmd_wr) begin
          pend_d  = 1'b0;
          err_d   = '0;
          start_d = 1'b1;
          opc_d   = avs_writedata_i[akp_pkg::CMD_OPC_LSB +: akp_pkg::OPC_W];
          ident_d = avs_writedata_i[akp_pkg::CMD_IDENT_BIT];
          first_d = 1'b1;
          full_d  = 1'b0;
          if (pio_d) begin
            cable_d = cable_detect_input_i;
            state_d = akp_pkg::S_PI_PREP;
          end else begin
            state_d = akp_pkg::S_ND_EXEC;
          end
        end
      end
      akp_pkg::S_ND_EXEC: begin
        if (nd_done_i) begin
          err_d   = error_i;
          pend_d  = 1'b1;
          state_d = akp_pkg::S_IDLE;
        end
      end
      akp_pkg::S_PI_PREP: begin
        if (prep_abort_i) begin
          err_d   = error_i;
          pend_d  = 1'b1;
          state_d = akp_pkg::S_IDLE;
        end else if (block_ready_i) begin
          wreq_d  = 1'b1;
          pend_d  = ~idis_q;
          state_d = idis_q ? akp_pkg::S_PI_XFER : akp_pkg::S_PI_RDY;
        end
      end
      akp_pkg::S_PI_RDY: begin
        if (sts_rd) begin
          pend_d  = 1'b0;
          state_d = akp_pkg::S_PI_XFER;
        end
      end
      akp_pkg::S_PI_XFER: begin
        if (data_rd) begin
          full_d = 1'b0;
          if (!last_word) begin
            wreq_d = 1'b1;
          end else if (!last_block) begin
            first_d = 1'b0;
            state_d = akp_pkg::S_PI_PREP;
          end else begin
            state_d = akp_pkg::S_IDLE;
          end
        end
      end
      default: begin
        state_d = akp_pkg::S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q  <= akp_pkg::S_IDLE;
      pend_q   <= 1'b0;
      line_q   <= 1'b0;
      idis_q   <= 1'b0;
      words_q  <= akp_pkg::RST_WORDS;
      blocks_q <= akp_pkg::RST_BLOCKS;
      err_q    <= '0;
      ident_q  <= 1'b0;
      cable_q  <= 1'b0;
      first_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      pend_q   <= pend_d;
      // the line follows pending gated by the disable bit
      line_q   <= pend_d & ~idis_d;
      idis_q   <= idis_d;
      words_q  <= words_d;
      blocks_q <= blocks_d;
      err_q    <= err_d;
      ident_q  <= ident_d;
      cable_q  <= cable_d;
      first_q  <= first_d;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_q  <= '0;
      full_q  <= 1'b0;
      wreq_q  <= 1'b0;
      start_q <= 1'b0;
      opc_q   <= '0;
      pio_q   <= 1'b0;
    end else begin
      data_q  <= data_d;
      full_q  <= full_d;
      wreq_q  <= wreq_d;
      start_q <= start_d;
      opc_q   <= opc_d;
      pio_q   <= cmd_wr ? pio_d : pio_q;
    end
  end

  // one-cycle answer: waitrequest drops for exactly one edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= akp_pkg::RST_ZERO;
    end else begin
      wait_q  <= ~acc;
      rdata_q <= acc_rd ? rdata_d : rdata_q;
    end
  end

  assign avs_readdata_o        = rdata_q;
  assign avs_waitrequest_o     = wait_q;
  assign host_interrupt_line_o = line_q;
  assign cmd_start_o           = start_q;
  assign cmd_opcode_o          = opc_q;
  assign cmd_pio_in_o          = pio_q;
  assign word_req_o            = wreq_q;

endmodule : akp_device

// ==== akp_device_chk.sv ====
// checker for the sequencer's bus, command and interrupt ports.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module akp_device_chk (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        host_interrupt_line_o,
  input wire logic        cmd_start_o,
  input wire logic [7:0]  cmd_opcode_o,
  input wire logic        cmd_pio_in_o,
  input wire logic        nd_done_i,
  input wire logic        prep_abort_i,
  input wire logic        block_ready_i
);
  // ********
  // protocol properties
  // ********
  wire req_w  = avs_read_i | avs_write_i;
  wire take_w = req_w & avs_waitrequest_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  chk_wait_single:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");
  chk_ack_prompt:
    assert property (take_w && avs_address_i != akp_pkg::REG_DATA
      |=> !avs_waitrequest_o) else $error("register access not answered");
  chk_ack_cause:
    assert property ($fell(avs_waitrequest_o) |-> $past(take_w))
    else $error("answer without a request");
  chk_start_cause:
    assert property (cmd_start_o |-> $past(take_w && avs_write_i)
      && $past(avs_address_i) == akp_pkg::REG_COMMAND
      && cmd_opcode_o == $past(avs_writedata_i[15:8])
      && cmd_pio_in_o == $past(avs_writedata_i[0]))
    else $error("command start without matching write");
  chk_start_pulse:
    assert property (cmd_start_o |=> !cmd_start_o)
    else $error("command start longer than a cycle");
  chk_irq_cause:
    assert property ($rose(host_interrupt_line_o)
      |-> $past(nd_done_i || prep_abort_i || block_ready_i))
    else $error("interrupt raised without a back-end event");
  chk_irq_clear:
    assert property (take_w && avs_read_i
      && avs_address_i == akp_pkg::REG_STATUS |=> !host_interrupt_line_o)
    else $error("status read left interrupt asserted");
  chk_irq_hold:
    assert property (host_interrupt_line_o && !req_w
      |=> host_interrupt_line_o) else $error("interrupt dropped by itself");
endmodule : akp_device_chk

bind akp_device akp_device_chk chk_u (.mclk_i, .nrst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
  .host_interrupt_line_o, .cmd_start_o, .cmd_opcode_o, .cmd_pio_in_o,
  .nd_done_i, .prep_abort_i, .block_ready_i);

// ==== akp_backend_model.sv ====
// back-end model: runs commands, readies blocks, supplies words.
// assumes the sequencer's back-end port; dly_i paces every answer.
`timescale 1ns/1ns
module akp_backend_model (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        cmd_start_i,
  input  wire logic        cmd_pio_in_i,
  input  wire logic        word_req_i,
  input  wire logic [7:0]  dly_i,
  input  wire logic [7:0]  err_i,
  input  wire logic [15:0] words_i,
  input  wire logic [15:0] blocks_i,
  output logic             nd_done_o,
  output logic             prep_abort_o,
  output logic      [7:0]  error_o,
  output logic             block_ready_o,
  output logic             word_valid_o,
  output logic      [15:0] word_data_o
);
  // ********
  // one countdown serves results, words and next blocks
  // ********
  logic [7:0]  t_q;
  logic [1:0]  k_q;
  logic        pio_q;
  logic [15:0] n_q;
  logic [15:0] b_q;
  wire         lastw_w = (n_q == words_i - 16'h0001);
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {t_q, k_q, pio_q, n_q, b_q} <= '0;
      {nd_done_o, prep_abort_o, block_ready_o, word_valid_o} <= '0;
      {error_o, word_data_o} <= '0;
    end else begin
      nd_done_o <= 1'b0;
      prep_abort_o <= 1'b0;
      word_valid_o <= 1'b0;
      error_o <= 8'h00;
      // released data line: no stale word to lean on
      word_data_o <= ~word_data_o;
      if (word_req_i)
        block_ready_o <= 1'b0;
      if (cmd_start_i) begin
        k_q <= 2'd1;
        t_q <= dly_i;
        pio_q <= cmd_pio_in_i;
        n_q <= 16'h0000;
        b_q <= 16'h0000;
      end else if (word_req_i) begin
        k_q <= 2'd2;
        t_q <= dly_i;
      end else if (k_q != 2'd0 && t_q != 8'h00) begin
        t_q <= t_q - 8'h01;
      end else if (k_q == 2'd1) begin
        k_q <= 2'd0;
        nd_done_o <= !pio_q;
        prep_abort_o <= pio_q && err_i != 8'h00;
        // a level, so a block readied early waits for preparation
        block_ready_o <= pio_q && err_i == 8'h00;
        error_o <= err_i;
      end else if (k_q == 2'd2) begin
        k_q <= (lastw_w && b_q + 16'h0001 < blocks_i) ? 2'd1 : 2'd0;
        t_q <= dly_i;
        word_valid_o <= 1'b1;
        word_data_o <= {b_q[7:0], n_q[7:0]};
        n_q <= lastw_w ? 16'h0000 : n_q + 16'h0001;
        b_q <= lastw_w ? b_q + 16'h0001 : b_q;
      end
    end
  end
endmodule : akp_backend_model

// ==== test_ata_nondata_pio_in_protocol.sv ====
// bench for the command sequencer: host by hand, back end modelled.
// assumes akp_pkg, akp_device, the back-end model and bound checker.
`timescale 1ns/1ns
module test_ata_nondata_pio_in_protocol;
  // ********
  // clock, reset and wiring
  // ********
  logic        mclk, rst_n, rd, wr, cable, done, abrt, brdy;
  logic        wait_s, irq, start, pio, wreq, wval;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [7:0]  opc, err_s, err_m, dly;
  logic [15:0] wdat, nw_s, nb_s;
  int          fails, total_checks;
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  akp_device dut_u (.mclk_i(mclk), .nrst_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_s), .host_interrupt_line_o(irq),
    .cable_detect_input_i(cable), .cmd_start_o(start), .cmd_opcode_o(opc),
    .cmd_pio_in_o(pio), .nd_done_i(done), .prep_abort_i(abrt),
    .error_i(err_m), .block_ready_i(brdy), .word_req_o(wreq),
    .word_valid_i(wval), .word_data_i(wdat));
  akp_backend_model model_u (.mclk_i(mclk), .nrst_i(rst_n),
    .cmd_start_i(start), .cmd_pio_in_i(pio), .word_req_i(wreq),
    .dly_i(dly), .err_i(err_s), .words_i(nw_s), .blocks_i(nb_s),
    .nd_done_o(done), .prep_abort_o(abrt), .error_o(err_m),
    .block_ready_o(brdy), .word_valid_o(wval), .word_data_o(wdat));
  // ********
  // shared tasks
  // ********
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_s !== 1'b0 && n < 400);
    if (wait_s !== 1'b0) begin
      fails++;
      $display("BAD bus wait expected 0 seen 1");
      tally_and_finish();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic rdm(input logic [4:0] a, input logic [31:0] m, e,
                     input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rdm
  // host waits: interrupt when enabled, alternate-status polling if not
  task automatic settle(input logic dis);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h80;
    while (n < 60 && (dis ? q[7] !== 1'b0 : irq !== 1'b1)) begin
      if (dis)
        bus(1'b0, akp_pkg::REG_ALT_STATUS, 32'h0, q);
      else
        @(posedge mclk);
      n++;
    end
    if (dis ? q[7] !== 1'b0 : irq !== 1'b1) begin
      fails++;
      $display("BAD settle expected 1 seen 0");
      tally_and_finish();
    end
    chk("irq gate", {31'h0, !dis}, {31'h0, irq});
  endtask : settle
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    logic [31:0] q;
    chk("wait", 32'h1, {31'h0, wait_s});
    chk("irq", 32'h0, {31'h0, irq});
    rdm(akp_pkg::REG_CONFIG, '1, 32'h0001_0100, "config");
    rdm(akp_pkg::REG_CONTROL, '1, 32'h0, "control");
    bus(1'b1, 5'h1c, 32'hffff_ffff, q);
    rdm(5'h1c, '1, 32'h0, "unmapped");
    rdm(akp_pkg::REG_STATUS, 32'h99, 32'h0, "idle status");
  endtask : t_reset
  task automatic t_nondata(input logic dis, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b1, akp_pkg::REG_CONTROL, {30'h0, dis, 1'b0}, q);
    dly <= 8'h0f;
    err_s <= e;
    bus(1'b1, akp_pkg::REG_COMMAND, 32'h0000_a500, q);
    rdm(akp_pkg::REG_ALT_STATUS, 32'h80, 32'h80, "nd busy");
    // a second command while busy must be ignored
    bus(1'b1, akp_pkg::REG_COMMAND, 32'h0000_5a01, q);
    chk("opcode", 32'h0a5, {23'h0, pio, opc});
    settle(dis);
    rdm(akp_pkg::REG_STATUS, 32'h99, 32'h10 | (e != 8'h00),
        "nd status");
    chk("irq clear", 32'h0, {31'h0, irq});
    rdm(akp_pkg::REG_ERROR, 32'hff, {24'h0, e}, "err code");
    rdm(akp_pkg::REG_STATUS, 32'h10, 32'h0, "pend clear");
  endtask : t_nondata
  task automatic t_datain(input logic dis, idf, cab,
                          input logic [15:0] nw, nb, input logic [7:0] d, e);
    logic [31:0] q;
    logic [15:0] x;
    int b;
    int w;
    bus(1'b1, akp_pkg::REG_CONTROL, {30'h0, dis, 1'b0}, q);
    bus(1'b1, akp_pkg::REG_CONFIG, {nb, nw}, q);
    nw_s <= nw;
    nb_s <= nb;
    dly <= d;
    err_s <= e;
    cable <= cab;
    bus(1'b1, akp_pkg::REG_COMMAND, {16'h0, 8'h20, 6'h0, idf, 1'b1}, q);
    rdm(akp_pkg::REG_ALT_STATUS, 32'h80, 32'h80, "pi busy");
    if (e != 8'h00) begin
      settle(dis);
      rdm(akp_pkg::REG_STATUS, 32'h99, 32'h11, "abort status");
      return;
    end
    for (b = 0; b < nb; b++) begin
      settle(dis);
      rdm(akp_pkg::REG_STATUS, 32'h99, dis ? 32'h08 : 32'h18,
          "block status");
      chk("irq xfer", 32'h0, {31'h0, irq});
      for (w = 0; w < nw; w++) begin
        x = {b[7:0], w[7:0]};
        if (idf && b == 0 && w == 93)
          x[13] = cab;
        rdm(akp_pkg::REG_DATA, 32'hffff, {16'h0, x}, "word");
      end
    end
    rdm(akp_pkg::REG_STATUS, 32'h99, 32'h0, "done status");
    chk("irq done", 32'h0, {31'h0, irq});
  endtask : t_datain
  initial begin
    {rst_n, rd, wr, cable} = '0;
    {addr, wdata, err_s, dly, nw_s, nb_s} = '0;
    {fails, total_checks} = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_nondata(1'b0, 8'h00);
    t_nondata(1'b1, 8'h04);
    t_datain(1'b0, 1'b0, 1'b0, 16'd4, 16'd3, 8'd3, 8'h00);
    t_datain(1'b1, 1'b0, 1'b0, 16'd2, 16'd2, 8'd15, 8'h00);
    t_datain(1'b0, 1'b1, 1'b1, 16'd100, 16'd1, 8'd3, 8'h00);
    t_datain(1'b1, 1'b1, 1'b0, 16'd100, 16'd1, 8'd3, 8'h00);
    t_datain(1'b0, 1'b0, 1'b0, 16'd4, 16'd1, 8'd3, 8'h21);
    t_datain(1'b1, 1'b0, 1'b0, 16'd4, 16'd1, 8'd15, 8'h21);
    tally_and_finish();
  end
endmodule : test_ata_nondata_pio_in_protocol
